// *** design/scc_pkg.sv ***
/*
 * constants, types and carriers of the system configuration block.
 * assumes an 8-bit register port with a 4-bit address, one clock.
 */
package scc_pkg;

  // register offsets
  localparam logic [3:0] ADDR_CLOCK_MODE_REG  = 4'h0;
  localparam logic [3:0] ADDR_XTAL   = 4'h1;
  localparam logic [3:0] ADDR_PADIE  = 4'h2;
  localparam logic [3:0] ADDR_INTERRUPT_ENABLE_REG  = 4'h3;
  localparam logic [3:0] ADDR_INTERRUPT_REQUEST_REG  = 4'h4;
  localparam logic [3:0] ADDR_INTERRUPT_EDGE_SELECT_REG = 4'h5;
  localparam logic [3:0] ADDR_T16CTL = 4'h6;
  localparam logic [3:0] ADDR_T16LO  = 4'h7;
  localparam logic [3:0] ADDR_T16HI  = 4'h8;
  localparam logic [3:0] ADDR_WDTCTL = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;

  // reset values
  localparam logic [7:0] CLOCK_MODE_REG_RST  = 8'hf6;
  localparam logic [7:0] XTAL_RST   = 8'h00;
  localparam logic [7:0] PADIE_RST  = 8'h00;
  localparam logic [7:0] INTERRUPT_EDGE_SELECT_REG_RST = 8'h00;
  localparam logic [7:0] T16CTL_RST = 8'h00;
  localparam logic [7:0] WDTCTL_RST = 8'h00;

  // field positions
  localparam int CLOCK_MODE_REG_EXTRST_BIT = 0;
  localparam int CLOCK_MODE_REG_WDT_BIT    = 1;
  localparam int CLOCK_MODE_REG_SLOW_BIT   = 2;
  localparam int CLOCK_MODE_REG_FAST_BIT   = 4;
  localparam int CLOCK_MODE_REG_SEL_LSB    = 5;
  localparam int XTAL_BAND_LSB    = 5;
  localparam int XTAL_EN_BIT      = 7;
  localparam int INTERRUPT_REQUEST_REG_T16_BIT    = 2;
  localparam int INTERRUPT_REQUEST_REG_CMP_BIT    = 4;
  localparam int INTERRUPT_EDGE_SELECT_REG_T16F_BIT  = 4;
  localparam int STAT_HANG_BIT    = 0;
  localparam int STAT_WDTO_BIT    = 1;
  localparam int RST_PIN          = 5;
  localparam int T16_BIT_BASE     = 8;

  // clock source selection codes
  localparam logic [2:0] SEL_SLOW = 3'b111;
  localparam logic [2:0] SEL_XTAL = 3'b011;

  localparam int PUSH_DEPTH = 4;
  localparam int WDT_W      = 19;

  typedef enum logic [1:0] {
    SCC_CMP_ALL,
    SCC_CMP_RISE,
    SCC_CMP_FALL
  } scc_cmp_edge_t;

  typedef enum logic [1:0] {
    SCC_SRC_FAST,
    SCC_SRC_SLOW,
    SCC_SRC_XTAL
  } scc_src_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } scc_bus_req_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       fast_en;
    logic       slow_en;
    logic       xtal_en;
    logic [1:0] xtal_band;
  } scc_osc_ctl_t;

endpackage

// *** design/scc_ctrl.sv ***
/*
 * system configuration and control: build options, wake-up, reset pin,
 * oscillator control, interrupt gating, flag save, watchdog, timer16.
 * assumes core strobes and ticks are single-cycle pulses on clk_i;
 * pins are asynchronous and pass a three-stage synchroniser.
 */
`timescale 1ns/1ns

// Behaviour
// - secure option blocks program memory readback
// - comparator irq edge chosen by option
// - pin wakes only when enable bit set
// - reset pin output is open drain
// - input pin plus mode bit0 resets
// - crystal bits 6:5 select drive band
// - crystal bit 7 enables oscillator
// - enable and request registers start undefined
// - global disable blocks every interrupt source
// - push saves, pop restores acc and flags
// - return from interrupt restores global enable
// - 0x36 selects fast/2; clearing bit2 stops slow
// - watchdog on at reset, calibration disables
// - watchdog halts while slow oscillator off
// - timer16 edge select defaults to rising
// - rising on bit8 fires every 512
// - falling on bit8 fires at 0x200 multiples
// - restart fires on next selected transition
// - watchdog clear restarts the count
module scc_ctrl #(
  parameter int WDT_TICKS_0 = 8192,
  parameter int WDT_TICKS_1 = 16384,
  parameter int WDT_TICKS_2 = 65536,
  parameter int WDT_TICKS_3 = 262144
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire scc_pkg::scc_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  input  wire logic                  opt_secure_i,
  input  wire logic [1:0]            opt_cmp_edge_i,
  input  wire logic                  pm_rd_i,
  input  wire logic [15:0]           pm_data_i,
  output logic [15:0]                pm_data_o,
  output logic                       pm_refused_o,
  input  wire logic                  cmp_i,
  input  wire logic [7:0]            pa_i,
  input  wire logic [7:0]            pa_in_mode_i,
  output logic                       wake_o,
  input  wire logic                  pa5_drv_i,
  input  wire logic                  pa5_val_i,
  output logic                       pa5_pad_o,
  output logic                       pa5_pad_oe_o,
  output logic                       ext_rst_o,
  output scc_pkg::scc_osc_ctl_t      osc_o,
  output logic                       cpu_hang_o,
  input  wire logic                  engint_i,
  input  wire logic                  disgint_i,
  input  wire logic                  reti_i,
  input  wire logic                  irq_ack_i,
  output logic                       irq_o,
  input  wire logic                  push_i,
  input  wire logic                  pop_i,
  input  wire logic [7:0]            acc_i,
  input  wire logic [3:0]            flags_i,
  output logic [7:0]                 acc_o,
  output logic [3:0]                 flags_o,
  input  wire logic                  calib_wdt_off_i,
  input  wire logic                  wdt_clear_i,
  input  wire logic                  slow_tick_i,
  output logic                       wdt_rst_o,
  input  wire logic                  t16_tick_i
);

  // which oscillator a selection code runs from
  function automatic scc_pkg::scc_src_t src_of(input logic [2:0] sel);
    if (sel == scc_pkg::SEL_SLOW) begin
      return scc_pkg::SCC_SRC_SLOW;
    end else if (sel == scc_pkg::SEL_XTAL) begin
      return scc_pkg::SCC_SRC_XTAL;
    end
    return scc_pkg::SCC_SRC_FAST;
  endfunction

  // enable bit of a source within clock mode and crystal fields
  function automatic logic src_on(input scc_pkg::scc_src_t s,
                                  input logic [7:0] cm,
                                  input logic [7:0] xt);
    case (s)
      scc_pkg::SCC_SRC_SLOW: return cm[scc_pkg::CLOCK_MODE_REG_SLOW_BIT];
      scc_pkg::SCC_SRC_XTAL: return xt[scc_pkg::XTAL_EN_BIT];
      default:               return cm[scc_pkg::CLOCK_MODE_REG_FAST_BIT];
    endcase
  endfunction

  localparam int WDT_W_L = scc_pkg::WDT_W;

  logic [7:0]  clock_mode_reg_q, clock_mode_reg_d;
  logic [7:0]  xtal_q;
  logic [7:0]  padie_q;
  logic [7:0]  interrupt_enable_reg_q;
  logic [7:0]  interrupt_request_reg_q, interrupt_request_reg_d;
  logic [7:0]  interrupt_edge_select_reg_q;
  logic [7:0]  t16ctl_q;
  logic [7:0]  wdtctl_q;
  logic [1:0]  stat_q, stat_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        secure_q;
  logic [1:0]  cmp_edge_q;
  logic        cmp_q;
  logic [7:0]  pa_s1_q, pa_s2_q, pa_s3_q;
  logic [7:0]  pa_lvl_q, pa_lvl_d;
  logic        wake_q;
  logic        ext_rst_q;
  logic        gie_q;
  logic        hang_q;
  logic [15:0] t16_q, t16_d;
  logic        t16_bit_q;
  logic [WDT_W_L-1:0] wdt_q;
  logic        wdt_rst_q;
  logic [15:0] pm_data_q;
  logic        pm_ref_q;
  logic [7:0]  acc_mem [scc_pkg::PUSH_DEPTH];
  logic [3:0]  flg_mem [scc_pkg::PUSH_DEPTH];
  logic [1:0]  sp_q;
  logic [7:0]  acc_q;
  logic [3:0]  flags_q;

  // register write decode
  wire wr_clock_mode_reg  = bus_i.we && bus_i.addr == scc_pkg::ADDR_CLOCK_MODE_REG;
  wire wr_xtal   = bus_i.we && bus_i.addr == scc_pkg::ADDR_XTAL;
  wire wr_padie  = bus_i.we && bus_i.addr == scc_pkg::ADDR_PADIE;
  wire wr_interrupt_enable_reg  = bus_i.we && bus_i.addr == scc_pkg::ADDR_INTERRUPT_ENABLE_REG;
  wire wr_interrupt_request_reg  = bus_i.we && bus_i.addr == scc_pkg::ADDR_INTERRUPT_REQUEST_REG;
  wire wr_interrupt_edge_select_reg = bus_i.we && bus_i.addr == scc_pkg::ADDR_INTERRUPT_EDGE_SELECT_REG;
  wire wr_t16ctl = bus_i.we && bus_i.addr == scc_pkg::ADDR_T16CTL;
  wire wr_t16lo  = bus_i.we && bus_i.addr == scc_pkg::ADDR_T16LO;
  wire wr_wdtctl = bus_i.we && bus_i.addr == scc_pkg::ADDR_WDTCTL;
  wire wr_status = bus_i.we && bus_i.addr == scc_pkg::ADDR_STATUS;

  // read mux, unmapped reads zero
  always_comb begin
    case (bus_i.addr)
      scc_pkg::ADDR_CLOCK_MODE_REG:  rdata_d = clock_mode_reg_q;
      scc_pkg::ADDR_XTAL:   rdata_d = xtal_q;
      scc_pkg::ADDR_PADIE:  rdata_d = padie_q;
      scc_pkg::ADDR_INTERRUPT_ENABLE_REG:  rdata_d = interrupt_enable_reg_q;
      scc_pkg::ADDR_INTERRUPT_REQUEST_REG:  rdata_d = interrupt_request_reg_q;
      scc_pkg::ADDR_INTERRUPT_EDGE_SELECT_REG: rdata_d = interrupt_edge_select_reg_q;
      scc_pkg::ADDR_T16CTL: rdata_d = t16ctl_q;
      scc_pkg::ADDR_T16LO:  rdata_d = t16_q[7:0];
      scc_pkg::ADDR_T16HI:  rdata_d = t16_q[15:8];
      scc_pkg::ADDR_WDTCTL: rdata_d = wdtctl_q;
      scc_pkg::ADDR_STATUS: rdata_d = {6'h00, stat_q};
      default:              rdata_d = 8'h00;
    endcase
    if (!bus_i.re) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata_o = rdata_q;

  // build options caught while reset is held
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      secure_q   <= opt_secure_i;
      cmp_edge_q <= opt_cmp_edge_i;
    end
  end

  // readback port: zeros and a refusal flag when secured
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pm_data_q <= 16'h0000;
      pm_ref_q  <= 1'b0;
    end else if (pm_rd_i) begin
      pm_data_q <= secure_q ? 16'h0000 : pm_data_i;
      pm_ref_q  <= secure_q;
    end
  end
  assign pm_data_o    = pm_data_q;
  assign pm_refused_o = pm_ref_q;

  // pin synchroniser; a change counts once stages two and three agree
  assign pa_lvl_d = (pa_s2_q & ~(pa_s2_q ^ pa_s3_q))
                  | (pa_lvl_q & (pa_s2_q ^ pa_s3_q));
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pa_s1_q  <= 8'hff;
      pa_s2_q  <= 8'hff;
      pa_s3_q  <= 8'hff;
      pa_lvl_q <= 8'hff;
    end else begin
      pa_s1_q  <= pa_i;
      pa_s2_q  <= pa_s1_q;
      pa_s3_q  <= pa_s2_q;
      pa_lvl_q <= pa_lvl_d;
    end
  end

  // wake on any filtered change of an enabled input pin
  wire [7:0] pa_chg = (pa_lvl_q ^ pa_lvl_d) & pa_in_mode_i & padie_q;

  // reset pin: input mode plus mode bit 0, active low
  wire ext_rst_d = pa_in_mode_i[scc_pkg::RST_PIN]
                 && clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_EXTRST_BIT]
                 && !pa_lvl_q[scc_pkg::RST_PIN];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_q    <= 1'b0;
      ext_rst_q <= 1'b0;
    end else begin
      wake_q    <= |pa_chg;
      ext_rst_q <= ext_rst_d;
    end
  end
  assign wake_o    = wake_q;
  assign ext_rst_o = ext_rst_q;

  // never drives high: a one releases the pad to the pull-up
  assign pa5_pad_o    = 1'b0;
  assign pa5_pad_oe_o = pa5_drv_i && !pa5_val_i;

  // clock switching; both moves in one write stop the core
  wire [2:0] sel_now = clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_SEL_LSB +: 3];
  wire [2:0] sel_new = bus_i.wdata[scc_pkg::CLOCK_MODE_REG_SEL_LSB +: 3];
  wire scc_pkg::scc_src_t old_src = src_of(sel_now);
  wire hang_hit = wr_clock_mode_reg && sel_new != sel_now
               && src_of(sel_new) != old_src
               && !src_on(old_src, bus_i.wdata, xtal_q);

  // calibration turns the watchdog off; it wins over a write
  always_comb begin
    clock_mode_reg_d = wr_clock_mode_reg ? bus_i.wdata : clock_mode_reg_q;
    if (calib_wdt_off_i) begin
      clock_mode_reg_d[scc_pkg::CLOCK_MODE_REG_WDT_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clock_mode_reg_q <= scc_pkg::CLOCK_MODE_REG_RST;
      hang_q  <= 1'b0;
    end else begin
      clock_mode_reg_q <= clock_mode_reg_d;
      hang_q  <= hang_q | hang_hit;
    end
  end
  assign cpu_hang_o = hang_q;

  assign osc_o.sel       = sel_now;
  assign osc_o.fast_en   = clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_FAST_BIT];
  assign osc_o.slow_en   = clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_SLOW_BIT];
  assign osc_o.xtal_en   = xtal_q[scc_pkg::XTAL_EN_BIT];
  assign osc_o.xtal_band = xtal_q[scc_pkg::XTAL_BAND_LSB +: 2];

  // plain configuration registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      xtal_q   <= scc_pkg::XTAL_RST;
      padie_q  <= scc_pkg::PADIE_RST;
      interrupt_edge_select_reg_q <= scc_pkg::INTERRUPT_EDGE_SELECT_REG_RST;
      t16ctl_q <= scc_pkg::T16CTL_RST;
      wdtctl_q <= scc_pkg::WDTCTL_RST;
    end else begin
      if (wr_xtal) begin
        xtal_q <= bus_i.wdata;
      end
      if (wr_padie) begin
        padie_q <= bus_i.wdata;
      end
      if (wr_interrupt_edge_select_reg) begin
        interrupt_edge_select_reg_q <= bus_i.wdata;
      end
      if (wr_t16ctl) begin
        t16ctl_q <= bus_i.wdata;
      end
      if (wr_wdtctl) begin
        wdtctl_q <= bus_i.wdata;
      end
    end
  end

  // comparator edge per build option
  wire cmp_rise = cmp_i && !cmp_q;
  wire cmp_fall = !cmp_i && cmp_q;
  logic cmp_evt;
  always_comb begin
    case (scc_pkg::scc_cmp_edge_t'(cmp_edge_q))
      scc_pkg::SCC_CMP_RISE: cmp_evt = cmp_rise;
      scc_pkg::SCC_CMP_FALL: cmp_evt = cmp_fall;
      default:               cmp_evt = cmp_rise | cmp_fall;
    endcase
  end

  // timer16: a write to the low byte restarts from zero
  wire [2:0] t16_sel = t16ctl_q[2:0];
  wire [3:0] t16_idx = 4'(scc_pkg::T16_BIT_BASE) + {1'b0, t16_sel};
  assign t16_d = wr_t16lo ? 16'h0000
               : t16_q + {15'h0000, t16_tick_i};
  wire t16_bit_d = t16_d[t16_idx];
  wire t16_fall_sel = interrupt_edge_select_reg_q[scc_pkg::INTERRUPT_EDGE_SELECT_REG_T16F_BIT];
  // restart reloads the edge memory, so only a new transition counts
  wire t16_evt = !wr_t16lo && (t16_fall_sel
               ? (t16_bit_q && !t16_bit_d)
               : (!t16_bit_q && t16_bit_d));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmp_q     <= 1'b0;
      t16_q     <= 16'h0000;
      t16_bit_q <= 1'b0;
    end else begin
      cmp_q     <= cmp_i;
      t16_q     <= t16_d;
      t16_bit_q <= t16_bit_d;
    end
  end

  // requests: hardware set wins over a software write
  always_comb begin
    interrupt_request_reg_d = wr_interrupt_request_reg ? bus_i.wdata : interrupt_request_reg_q;
    interrupt_request_reg_d[scc_pkg::INTERRUPT_REQUEST_REG_T16_BIT] = interrupt_request_reg_d[scc_pkg::INTERRUPT_REQUEST_REG_T16_BIT]
                                    | t16_evt;
    interrupt_request_reg_d[scc_pkg::INTERRUPT_REQUEST_REG_CMP_BIT] = interrupt_request_reg_d[scc_pkg::INTERRUPT_REQUEST_REG_CMP_BIT]
                                    | cmp_evt;
  end

  // no reset: software must load both before enabling
  always_ff @(posedge clk_i) begin
    interrupt_request_reg_q <= interrupt_request_reg_d;
    if (wr_interrupt_enable_reg) begin
      interrupt_enable_reg_q <= bus_i.wdata;
    end
  end

  // global enable; entry clears it, return restores it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gie_q <= 1'b0;
    end else if (disgint_i || irq_ack_i) begin
      gie_q <= 1'b0;
    end else if (engint_i || reti_i) begin
      gie_q <= 1'b1;
    end
  end
  assign irq_o = gie_q && |(interrupt_enable_reg_q & interrupt_request_reg_q);

  // accumulator and flags save stack
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      acc_mem[sp_q] <= acc_i;
      flg_mem[sp_q] <= flags_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sp_q    <= 2'h0;
      acc_q   <= 8'h00;
      flags_q <= 4'h0;
    end else if (push_i) begin
      sp_q <= sp_q + 2'h1;
    end else if (pop_i) begin
      sp_q    <= sp_q - 2'h1;
      acc_q   <= acc_mem[sp_q - 2'h1];
      flags_q <= flg_mem[sp_q - 2'h1];
    end
  end
  assign acc_o   = acc_q;
  assign flags_o = flags_q;

  // watchdog counts slow-oscillator ticks only
  logic [WDT_W_L-1:0] wdt_lim;
  always_comb begin
    case (wdtctl_q[1:0])
      2'h0:    wdt_lim = WDT_W_L'(WDT_TICKS_0);
      2'h1:    wdt_lim = WDT_W_L'(WDT_TICKS_1);
      2'h2:    wdt_lim = WDT_W_L'(WDT_TICKS_2);
      default: wdt_lim = WDT_W_L'(WDT_TICKS_3);
    endcase
  end
  wire wdt_run = clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_WDT_BIT]
              && clock_mode_reg_q[scc_pkg::CLOCK_MODE_REG_SLOW_BIT];
  // a clear in the final tick still postpones the timeout
  wire wdt_to = wdt_run && slow_tick_i && !wdt_clear_i
             && wdt_q == wdt_lim - WDT_W_L'(1);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wdt_q     <= '0;
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= wdt_to;
      if (wdt_clear_i || wdt_to) begin
        wdt_q <= '0;
      end else if (wdt_run && slow_tick_i) begin
        wdt_q <= wdt_q + WDT_W_L'(1);
      end
    end
  end
  assign wdt_rst_o = wdt_rst_q;

  // status: sticky, write one to clear, set wins
  always_comb begin
    stat_d = stat_q;
    if (wr_status) begin
      stat_d = stat_q & ~bus_i.wdata[1:0];
    end
    stat_d[scc_pkg::STAT_HANG_BIT] = stat_d[scc_pkg::STAT_HANG_BIT]
                                   | hang_hit;
    stat_d[scc_pkg::STAT_WDTO_BIT] = stat_d[scc_pkg::STAT_WDTO_BIT]
                                   | wdt_to;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

endmodule

// *** verif/scc_ctrl_properties.sv ***
/*
 * port-level properties of the system configuration block.
 * assumes the block's own clock and synchronous reset; bound below.
 */
`timescale 1ns/1ns
module scc_ctrl_properties (
  input logic                  clk_i,
  input logic                  sys_rst_i,
  input scc_pkg::scc_bus_req_t bus_i,
  input logic [7:0]            rdata_o,
  input logic                  pm_rd_i,
  input logic [15:0]           pm_data_i,
  input logic [15:0]           pm_data_o,
  input logic                  pm_refused_o,
  input logic                  pa5_drv_i,
  input logic                  pa5_val_i,
  input logic                  pa5_pad_o,
  input logic                  pa5_pad_oe_o,
  input scc_pkg::scc_osc_ctl_t osc_o,
  input logic                  cpu_hang_o,
  input logic                  disgint_i,
  input logic                  irq_o,
  input logic                  wdt_clear_i,
  input logic                  wdt_rst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic xw;
  assign xw = bus_i.we && bus_i.addr == scc_pkg::ADDR_XTAL;

  property p_pm_secure;
    pm_rd_i |=> (pm_refused_o ? pm_data_o == 16'h0000
                              : pm_data_o == $past(pm_data_i));
  endproperty
  a_pm_secure: assert property (p_pm_secure)
    else $error("readback word wrong");
  property p_pad;
    pa5_pad_o == 1'b0 && pa5_pad_oe_o == (pa5_drv_i & ~pa5_val_i);
  endproperty
  a_pad: assert property (p_pad)
    else $error("pin 5 drives high");
  property p_xband;
    xw |=> osc_o.xtal_band == $past(bus_i.wdata[6:5]);
  endproperty
  a_xband: assert property (p_xband)
    else $error("crystal band mismatch");
  property p_xen;
    xw |=> osc_o.xtal_en == $past(bus_i.wdata[7]);
  endproperty
  a_xen: assert property (p_xen)
    else $error("crystal enable mismatch");
  property p_gdis;
    disgint_i |=> !irq_o;
  endproperty
  a_gdis: assert property (p_gdis)
    else $error("irq after global disable");
  property p_clk36;
    bus_i.we && bus_i.addr == scc_pkg::ADDR_CLOCK_MODE_REG && bus_i.wdata == 8'h36
      |=> osc_o.sel == 3'b001 && osc_o.fast_en && osc_o.slow_en;
  endproperty
  a_clk36: assert property (p_clk36)
    else $error("fast/2 selection wrong");
  property p_wdt_slow;
    wdt_rst_o |-> $past(osc_o.slow_en);
  endproperty
  a_wdt_slow: assert property (p_wdt_slow)
    else $error("timeout with slow osc off");
  property p_wdt_clr;
    wdt_clear_i |=> !wdt_rst_o;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr)
    else $error("timeout right after clear");
  property p_rd_idle;
    !bus_i.re |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");

  c_refused: cover property (pm_rd_i ##1 pm_refused_o);
  c_wdt: cover property (wdt_rst_o);
  c_irq: cover property (irq_o);
  c_hang: cover property ($rose(cpu_hang_o));
endmodule

bind scc_ctrl scc_ctrl_properties u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .pm_rd_i(pm_rd_i), .pm_data_i(pm_data_i),
  .pm_data_o(pm_data_o), .pm_refused_o(pm_refused_o),
  .pa5_drv_i(pa5_drv_i), .pa5_val_i(pa5_val_i), .pa5_pad_o(pa5_pad_o),
  .pa5_pad_oe_o(pa5_pad_oe_o), .osc_o(osc_o), .cpu_hang_o(cpu_hang_o),
  .disgint_i(disgint_i), .irq_o(irq_o), .wdt_clear_i(wdt_clear_i),
  .wdt_rst_o(wdt_rst_o)
);

// *** verif/test_scc_ctrl.sv ***
/*
 * self-checking bench of the system configuration block.
 * assumes the package and design compiled first; short watchdog counts.
 */
`timescale 1ns/1ns
module test_scc_ctrl;
  logic                  clk_i = 1'b0;
  logic                  sys_rst_i = 1'b1;
  scc_pkg::scc_bus_req_t bus_q = '0;
  // pulses: 0 en 1 dis 2 reti 3 ack 4 push 5 pop 6 calib 7 wclr 8 slow
  // 9 t16 10 pm read
  logic [10:0]           pl_q = '0;
  logic                  sec_q = 1'b1;
  logic [1:0]            edge_q = 2'h1;
  logic                  cmp_q = 1'b0;
  logic [7:0]            pa_q = 8'hff;
  logic [7:0]            mode_q = 8'hff;
  logic [7:0]            acc_q = 8'h00;
  logic [3:0]            flg_q = 4'h0;
  logic                  drv_q = 1'b0;
  logic                  val_q = 1'b0;
  logic [7:0]            rdata_o;
  logic [15:0]           pm_data_o;
  logic                  pm_refused_o, wake_o, pa5_pad_o, pa5_pad_oe_o;
  logic                  ext_rst_o, cpu_hang_o, irq_o, wdt_rst_o;
  scc_pkg::scc_osc_ctl_t osc_o;
  logic [7:0]            acc_o;
  logic [3:0]            flags_o;
  int                    err_count = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  int                    wdt_n = 0;
  int                    wake_n = 0;

  scc_ctrl #(.WDT_TICKS_0(8), .WDT_TICKS_1(16), .WDT_TICKS_2(32),
    .WDT_TICKS_3(64)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_q), .rdata_o(rdata_o),
    .opt_secure_i(sec_q), .opt_cmp_edge_i(edge_q), .pm_rd_i(pl_q[10]),
    .pm_data_i(16'h1234), .pm_data_o(pm_data_o),
    .pm_refused_o(pm_refused_o), .cmp_i(cmp_q), .pa_i(pa_q),
    .pa_in_mode_i(mode_q), .wake_o(wake_o), .pa5_drv_i(drv_q),
    .pa5_val_i(val_q), .pa5_pad_o(pa5_pad_o), .pa5_pad_oe_o(pa5_pad_oe_o),
    .ext_rst_o(ext_rst_o), .osc_o(osc_o), .cpu_hang_o(cpu_hang_o),
    .engint_i(pl_q[0]), .disgint_i(pl_q[1]), .reti_i(pl_q[2]),
    .irq_ack_i(pl_q[3]), .irq_o(irq_o), .push_i(pl_q[4]), .pop_i(pl_q[5]),
    .acc_i(acc_q), .flags_i(flg_q), .acc_o(acc_o), .flags_o(flags_o),
    .calib_wdt_off_i(pl_q[6]), .wdt_clear_i(pl_q[7]),
    .slow_tick_i(pl_q[8]), .wdt_rst_o(wdt_rst_o), .t16_tick_i(pl_q[9]));

  always #4 clk_i = ~clk_i;

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the full sequence needs well under 5000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (wdt_rst_o === 1'b1) wdt_n++;
    if (wake_o === 1'b1) wake_n++;
    if (cyc == 8000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i) bus_q <= {a, d, 2'b10};
    @(posedge clk_i) bus_q <= '0;
    #1;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i) bus_q <= {a, 8'h00, 2'b01};
    @(posedge clk_i) bus_q <= '0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clk_i) pl_q <= 11'h001 << i;
      @(posedge clk_i) pl_q <= '0;
    end
    #1;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_rst;
    @(posedge clk_i) sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
  endtask

  task automatic cstep(input logic v, input logic [7:0] e);
    @(posedge clk_i) cmp_q <= v;
    wait_c(2);
    rdc(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, e);
  endtask

  task automatic t16(input int n, input logic [7:0] e);
    pulse(9, n);
    rdc(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, e);
  endtask

  initial begin
    do_rst();
    rdc(scc_pkg::ADDR_CLOCK_MODE_REG, 8'hf6);
    rdc(scc_pkg::ADDR_INTERRUPT_EDGE_SELECT_REG, 8'h00);
    rdc(4'hf, 8'h00);
    pulse(10, 1);
    chk(pm_data_o, 16'h0000);
    chk({15'h0, pm_refused_o}, 16'h0001);
    for (int b = 1; b < 4; b++) begin
      wr(scc_pkg::ADDR_XTAL, {1'b1, 2'(b), 5'h00});
      chk(16'(osc_o.xtal_band), 16'(b));
      chk(16'(osc_o.xtal_en), 16'h0001);
    end
    wr(scc_pkg::ADDR_XTAL, 8'h00);
    chk(16'(osc_o.xtal_en), 16'h0000);
    @(posedge clk_i) drv_q <= 1'b1;
    wait_c(1);
    chk({14'h0, pa5_pad_o, pa5_pad_oe_o}, 16'h0001);
    @(posedge clk_i) val_q <= 1'b1;
    wait_c(1);
    chk({14'h0, pa5_pad_o, pa5_pad_oe_o}, 16'h0000);
    @(posedge clk_i) {acc_q, flg_q} <= 12'h5aa;
    pulse(4, 1);
    @(posedge clk_i) {acc_q, flg_q} <= 12'hc35;
    pulse(4, 1);
    pulse(5, 1);
    chk({4'h0, acc_o, flags_o}, 16'h0c35);
    pulse(5, 1);
    chk({4'h0, acc_o, flags_o}, 16'h05aa);
    wr(scc_pkg::ADDR_PADIE, 8'h01);
    @(posedge clk_i) pa_q <= 8'hfd;
    wait_c(8);
    chk(16'(wake_n), 16'h0000);
    @(posedge clk_i) pa_q <= 8'hfc;
    wait_c(8);
    chk(16'(wake_n), 16'h0001);
    wr(scc_pkg::ADDR_INTERRUPT_ENABLE_REG, 8'h14);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    cstep(1'b1, 8'h10);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    cstep(1'b0, 8'h00);
    pulse(8, 7);
    pulse(7, 1);
    pulse(8, 7);
    wait_c(2);
    chk(16'(wdt_n), 16'h0000);
    pulse(8, 1);
    wait_c(2);
    chk(16'(wdt_n), 16'h0001);
    rdc(scc_pkg::ADDR_STATUS, 8'h02);
    wr(scc_pkg::ADDR_STATUS, 8'h02);
    rdc(scc_pkg::ADDR_STATUS, 8'h00);
    // software order: restart timer16, clear requests, then global enable
    wr(scc_pkg::ADDR_T16LO, 8'h00);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    pulse(0, 1);
    t16(255, 8'h00);
    t16(1, 8'h04);
    rdc(scc_pkg::ADDR_T16HI, 8'h01);
    chk({15'h0, irq_o}, 16'h0001);
    pulse(1, 1);
    chk({15'h0, irq_o}, 16'h0000);
    pulse(2, 1);
    chk({15'h0, irq_o}, 16'h0001);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    t16(511, 8'h00);
    t16(1, 8'h04);
    pulse(9, 128);
    wr(scc_pkg::ADDR_T16LO, 8'h00);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    t16(255, 8'h00);
    t16(1, 8'h04);
    wr(scc_pkg::ADDR_INTERRUPT_EDGE_SELECT_REG, 8'h10);
    wr(scc_pkg::ADDR_T16LO, 8'h00);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    t16(511, 8'h00);
    t16(1, 8'h04);
    wr(scc_pkg::ADDR_CLOCK_MODE_REG, 8'h36);
    chk({8'h00, osc_o}, 16'h0038);
    chk({15'h0, cpu_hang_o}, 16'h0000);
    wr(scc_pkg::ADDR_CLOCK_MODE_REG, 8'h32);
    chk({8'h00, osc_o}, 16'h0030);
    chk({15'h0, cpu_hang_o}, 16'h0000);
    pulse(8, 10);
    wait_c(2);
    chk(16'(wdt_n), 16'h0001);
    pulse(6, 1);
    rdc(scc_pkg::ADDR_CLOCK_MODE_REG, 8'h30);
    wr(scc_pkg::ADDR_PADIE, 8'h00);
    wr(scc_pkg::ADDR_XTAL, 8'he0);
    wr(scc_pkg::ADDR_CLOCK_MODE_REG, 8'h70);
    chk({8'h00, osc_o}, 16'h0077);
    chk({15'h0, cpu_hang_o}, 16'h0000);
    // second reset mid-run with the other build options
    sec_q <= 1'b0;
    edge_q <= 2'h2;
    do_rst();
    pulse(10, 1);
    chk(pm_data_o, 16'h1234);
    chk({15'h0, pm_refused_o}, 16'h0000);
    wr(scc_pkg::ADDR_INTERRUPT_REQUEST_REG, 8'h00);
    cstep(1'b1, 8'h00);
    cstep(1'b0, 8'h10);
    wr(scc_pkg::ADDR_CLOCK_MODE_REG, 8'hf7);
    @(posedge clk_i) pa_q <= 8'hdf;
    wait_c(8);
    chk({15'h0, ext_rst_o}, 16'h0001);
    @(posedge clk_i) mode_q <= 8'hdf;
    wait_c(8);
    chk({15'h0, ext_rst_o}, 16'h0000);
    wr(scc_pkg::ADDR_CLOCK_MODE_REG, 8'h50);
    wait_c(1);
    chk({15'h0, cpu_hang_o}, 16'h0001);
    rdc(scc_pkg::ADDR_STATUS, 8'h01);
    complete_run();
  end
endmodule
